// ---- inc/ppfs_pkg.sv ----
// Constants, types and reset values for the port pin function select block.
// Assumes an APB3 master on the system clock and a 32-bit data path.
// ----------------------------------------------------------------------
// How it works
// - Six port register groups, 0x100 apart, first port lowest.
// - Function select at 0x00, pin type at 0x04, both read/write.
// - Pull-up at 0x08 and debounce enable at 0x0C, both read/write.
// - Two-bit function field per pin; 00 is general I/O, else alternate.
// - First port: 11 analog 0-15, 01 SPI on 12-15, 10 timers on 4-7.
// - Second port: 01 motor PWM and protection inputs; 10 timer, watchdog, UART.
// - Third port: 01 debug, reset and serial functions; 11 crystal on 12-13.
// - Third port function select resets with pins 0-4 and 10 at 01.
// - Fourth port: 01 SPI, I2C, UART, converter; 11 sub-osc and analog.
// - Fifth port: 10 UART, timers, I2C; 01 on 11-15 timer copies.
// - Sixth port has six fields; 11 on pins 2-3 analog; upper bits zero.
// - Secondary placements are selected independently through each pin's field.
// - The default function of every pin is its selection after reset.
// - Pin type field per pin: 00 push-pull, 01 open-drain, 10 input, 11 analog.
// - All ports but the third reset every pin type to analog.
// - Third port pin types reset to input, push-pull on 2, else analog.
// - Config writes only after unlock pair 0x15 then 0x51; other value relocks.
// ----------------------------------------------------------------------
package ppfs_pkg;
    // ------------------------------------------------------------------
    // Address map
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 6;
    localparam logic [15:0] PORT_BASE = 16'h1000;
    localparam logic [15:0] PORT_STRIDE = 16'h0100;
    localparam logic [7:0] OFS_FUNC_SEL = 8'h00;
    localparam logic [7:0] OFS_PIN_TYPE = 8'h04;
    localparam logic [7:0] OFS_PULL_UP = 8'h08;
    localparam logic [7:0] OFS_DEBOUNCE = 8'h0C;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MODE = 8'h18;
    localparam logic [15:0] OFS_UNLOCK = 16'h1FF0;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h15;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h51;
    // ------------------------------------------------------------------
    // Field codes and reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] FUNC_GPIO = 2'h0;
    localparam logic [1:0] FUNC_ALT1 = 2'h1;
    localparam logic [1:0] FUNC_ALT2 = 2'h2;
    localparam logic [1:0] FUNC_ALT3 = 2'h3;
    localparam logic [1:0] TYPE_PUSH_PULL = 2'h0;
    localparam logic [1:0] TYPE_OPEN_DRAIN = 2'h1;
    localparam logic [1:0] TYPE_INPUT = 2'h2;
    localparam logic [1:0] TYPE_ANALOG = 2'h3;
    localparam logic [31:0] FUNC_RST_DEF = 32'h0000_0000;
    localparam logic [31:0] FUNC_RST_PC = 32'h0010_0155;
    localparam logic [31:0] TYPE_RST_DEF = 32'hFFFF_FFFF;
    localparam logic [31:0] TYPE_RST_PC = 32'hFFAF_FE8A;
    localparam logic [31:0] PORTF_MASK = 32'h0000_0FFF;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    localparam int PORTC_IDX = 2;
    localparam int PORTF_IDX = 5;

    // Per-pin digital controls for one port
    typedef struct packed {
        logic [15:0] out_en;
        logic [15:0] in_en;
        logic [15:0] analog_en;
        logic [15:0] open_drain;
    } ppfs_pin_ctl_t;

    // APB slave request
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } ppfs_apb_req_t;
endpackage

// ---- src/ppfs_top.sv ----
// Port pin function select block: six port register groups on APB.
// Assumes a synchronous APB3 master on core_clk_in; peripheral muxing
// downstream reads the function and type fields this block exports.
`timescale 1ns/10ps
module ppfs_top (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire ppfs_pkg::ppfs_apb_req_t apb_req_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic unlocked_out,
    output logic [ppfs_pkg::NUM_PORTS*32-1:0] func_sel_out,
    output logic [ppfs_pkg::NUM_PORTS*32-1:0] pin_type_out,
    output logic [ppfs_pkg::NUM_PORTS*16-1:0] pull_up_out,
    output logic [ppfs_pkg::NUM_PORTS*16-1:0] debounce_out,
    output ppfs_pkg::ppfs_pin_ctl_t [ppfs_pkg::NUM_PORTS-1:0] pin_ctl_out
);
    import ppfs_pkg::*;

    typedef enum logic [1:0] {
        LK_LOCKED,
        LK_KEY1_SEEN,
        LK_OPEN
    } ppfs_lock_t;

    // ------------------------------------------------------------------
    // Storage, one word per register per port
    // ------------------------------------------------------------------
    logic [31:0] func_ff [NUM_PORTS];
    logic [31:0] type_ff [NUM_PORTS];
    logic [15:0] pull_ff [NUM_PORTS];
    logic [15:0] deb_ff [NUM_PORTS];
    logic [31:0] irq_en_ff [NUM_PORTS];
    logic [31:0] irq_st_ff [NUM_PORTS];
    logic [31:0] irq_md_ff [NUM_PORTS];
    logic [31:0] prdata_ff;
    logic rd_fresh_ff;
    ppfs_lock_t lock_ff;

    logic acc;
    logic wr;
    logic rd;
    logic hit_unlock;
    logic hit_port;
    logic [2:0] port_idx;
    logic [7:0] reg_ofs;
    logic cfg_we;
    logic [31:0] rd_val;
    logic map_ok;

    // Reset image of the function select per port
    function automatic logic [31:0] func_rst(input int p);
        return (p == PORTC_IDX) ? FUNC_RST_PC : FUNC_RST_DEF;
    endfunction

    // Reset image of the pin type per port
    function automatic logic [31:0] type_rst(input int p);
        if (p == PORTC_IDX) begin
            return TYPE_RST_PC;
        end
        if (p == PORTF_IDX) begin
            return TYPE_RST_DEF & PORTF_MASK;
        end
        return TYPE_RST_DEF;
    endfunction

    // Mask of implemented field bits per port
    function automatic logic [31:0] impl_mask(input int p);
        return (p == PORTF_IDX) ? PORTF_MASK : 32'hFFFF_FFFF;
    endfunction

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Writes end in the first access cycle; reads once the word fetched
    // in setup stands on prdata, so the master takes it at ready
    assign acc = apb_req_in.psel & apb_req_in.penable & pready_out;
    assign wr = acc & apb_req_in.pwrite;
    assign rd = acc & ~apb_req_in.pwrite;
    assign hit_unlock = (apb_req_in.paddr == OFS_UNLOCK);
    assign port_idx = 3'(apb_req_in.paddr[10:8]);
    assign reg_ofs = apb_req_in.paddr[7:0];
    assign hit_port = (apb_req_in.paddr[15:11] == PORT_BASE[15:11]) &&
                      (port_idx < 3'(NUM_PORTS));
    assign cfg_we = wr & hit_port & (lock_ff == LK_OPEN);
    assign pready_out = clk_en_in & (apb_req_in.pwrite | rd_fresh_ff);
    assign prdata_out = prdata_ff;
    assign unlocked_out = (lock_ff == LK_OPEN);

    // Read mux and decode check; unmapped offsets answer with an error
    always_comb begin
        rd_val = 32'h0000_0000;
        map_ok = 1'b0;
        if (hit_unlock) begin
            map_ok = 1'b1;
            rd_val = {31'h0000_0000, lock_ff == LK_OPEN};
        end else if (hit_port) begin
            map_ok = 1'b1;
            unique case (reg_ofs)
                OFS_FUNC_SEL: rd_val = func_ff[port_idx];
                OFS_PIN_TYPE: rd_val = type_ff[port_idx];
                OFS_PULL_UP: rd_val = {16'h0000, pull_ff[port_idx]};
                OFS_DEBOUNCE: rd_val = {16'h0000, deb_ff[port_idx]};
                OFS_IRQ_EN: rd_val = irq_en_ff[port_idx];
                OFS_IRQ_STAT: rd_val = irq_st_ff[port_idx];
                OFS_IRQ_MODE: rd_val = irq_md_ff[port_idx];
                default: map_ok = 1'b0;
            endcase
        end
    end

    assign pslverr_out = acc & ~map_ok;

    // Read word fetched in setup, so it already stands at the ready edge;
    // a setup frozen by the clock enable costs one wait cycle instead
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            prdata_ff <= ZERO_RST;
            rd_fresh_ff <= 1'b0;
        end else if (clk_en_in && apb_req_in.psel && !apb_req_in.pwrite && !rd_fresh_ff) begin
            prdata_ff <= rd_val;
            rd_fresh_ff <= 1'b1;
        end else if (rd) begin
            rd_fresh_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Write protection sequence
    // ------------------------------------------------------------------
    // Any read between the two keys spoils the sequence
    always_ff @(posedge core_clk_in) begin
        if (!resetn_in) begin
            lock_ff <= LK_LOCKED;
        end else if (wr && hit_unlock) begin
            if (apb_req_in.pwdata[7:0] == UNLOCK_KEY1) begin
                lock_ff <= LK_KEY1_SEEN;
            end else if (apb_req_in.pwdata[7:0] == UNLOCK_KEY2 && lock_ff == LK_KEY1_SEEN) begin
                lock_ff <= LK_OPEN;
            end else begin
                lock_ff <= LK_LOCKED;
            end
        end else if (rd && lock_ff == LK_KEY1_SEEN) begin
            lock_ff <= LK_LOCKED;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // Each alternate is its own field code, so copies of a signal on
    // several pins are chosen pin by pin
    always_ff @(posedge core_clk_in) begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (!resetn_in) begin
                func_ff[p] <= func_rst(p);
                type_ff[p] <= type_rst(p);
                pull_ff[p] <= 16'h0000;
                deb_ff[p] <= 16'h0000;
                irq_en_ff[p] <= ZERO_RST;
                irq_st_ff[p] <= ZERO_RST;
                irq_md_ff[p] <= ZERO_RST;
            end else if (cfg_we && port_idx == 3'(p)) begin
                unique case (reg_ofs)
                    OFS_FUNC_SEL: func_ff[p] <= apb_req_in.pwdata & impl_mask(p);
                    OFS_PIN_TYPE: type_ff[p] <= apb_req_in.pwdata & impl_mask(p);
                    OFS_PULL_UP: pull_ff[p] <= apb_req_in.pwdata[15:0];
                    OFS_DEBOUNCE: deb_ff[p] <= apb_req_in.pwdata[15:0];
                    OFS_IRQ_EN: irq_en_ff[p] <= apb_req_in.pwdata;
                    OFS_IRQ_STAT: irq_st_ff[p] <= apb_req_in.pwdata;
                    OFS_IRQ_MODE: irq_md_ff[p] <= apb_req_in.pwdata;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin control outputs
    // ------------------------------------------------------------------
    // Per-port alternate routing is done by
    // the peripheral mux from func_sel_out; here only the pad enables
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            func_sel_out[p*32 +: 32] = func_ff[p];
            pin_type_out[p*32 +: 32] = type_ff[p];
            pull_up_out[p*16 +: 16] = pull_ff[p];
            debounce_out[p*16 +: 16] = deb_ff[p];
            for (int n = 0; n < 16; n++) begin
                // Analog wins over any function so the ADC sees a quiet pad
                pin_ctl_out[p].analog_en[n] = (type_ff[p][2*n +: 2] == TYPE_ANALOG);
                pin_ctl_out[p].out_en[n] = (type_ff[p][2*n +: 2] == TYPE_PUSH_PULL) ||
                                           (type_ff[p][2*n +: 2] == TYPE_OPEN_DRAIN);
                pin_ctl_out[p].open_drain[n] = (type_ff[p][2*n +: 2] == TYPE_OPEN_DRAIN);
                pin_ctl_out[p].in_en[n] = (type_ff[p][2*n +: 2] != TYPE_ANALOG);
            end
        end
    end
endmodule // ppfs_top

// ---- tb/ppfs_props.sv ----
// Checker for the port pin function select block, bound to its top ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module ppfs_props (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire ppfs_pkg::ppfs_apb_req_t apb_req_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic unlocked_out,
    input wire logic [ppfs_pkg::NUM_PORTS*32-1:0] func_sel_out,
    input wire logic [ppfs_pkg::NUM_PORTS*32-1:0] pin_type_out,
    input wire ppfs_pkg::ppfs_pin_ctl_t [ppfs_pkg::NUM_PORTS-1:0] pin_ctl_out
);
    import ppfs_pkg::*;
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Taken write, with clock enable, since a frozen edge stores nothing
    logic wr_go;
    assign wr_go = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && clk_en_in;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    write_ready_a: assert property (apb_req_in.psel && apb_req_in.pwrite |->
        pready_out == clk_en_in) else $error("write ready wrong");
    read_ready_a: assert property ((apb_req_in.psel && !apb_req_in.penable &&
        !apb_req_in.pwrite && clk_en_in) ##1 (apb_req_in.psel && apb_req_in.penable &&
        clk_en_in) |-> pready_out) else $error("read not ready");
    bad_ofs_a: assert property (apb_req_in.psel && apb_req_in.penable && pready_out &&
        apb_req_in.paddr == 16'h1020 |-> pslverr_out) else $error("no slave error");
    relock_val_a: assert property (wr_go && apb_req_in.paddr == 16'h1FF0 &&
        apb_req_in.pwdata[7:0] != 8'h15 && apb_req_in.pwdata[7:0] != 8'h51 |=> !unlocked_out)
        else $error("still unlocked");
    locked_hold_a: assert property (wr_go && !unlocked_out && apb_req_in.paddr == 16'h1000
        |=> func_sel_out[31:0] == $past(func_sel_out[31:0])) else $error("locked write taken");
    func_write_a: assert property (wr_go && unlocked_out && apb_req_in.paddr == 16'h1000
        |=> func_sel_out[31:0] == $past(apb_req_in.pwdata)) else $error("write lost");
    reset_func_a: assert property ($rose(resetn_in) |-> func_sel_out[64 +: 32] == 32'h0010_0155)
        else $error("port C default wrong");
    portf_zero_a: assert property (func_sel_out[172 +: 20] == 20'h0 &&
        pin_type_out[172 +: 20] == 20'h0) else $error("port F upper bits set");
    analog_off_a: assert property (pin_type_out[1:0] == 2'h3 |-> pin_ctl_out[0].analog_en[0]
        && !pin_ctl_out[0].out_en[0] && !pin_ctl_out[0].in_en[0]) else $error("analog drives");
    push_pull_a: assert property (pin_type_out[1:0] == 2'h0 |-> pin_ctl_out[0].out_en[0]
        && !pin_ctl_out[0].open_drain[0]) else $error("push-pull wrong");
    open_drain_a: assert property (pin_type_out[3:2] == 2'h1 |-> pin_ctl_out[0].out_en[1]
        && pin_ctl_out[0].open_drain[1]) else $error("open-drain wrong");
endmodule // ppfs_props

// ---- tb/ppfs_top_tb.sv ----
// Self-checking bench for the port pin function select block.
// Assumes the block raises pready itself; outputs are checked a cycle after a write.
`timescale 1ns/10ps
module ppfs_top_tb;
    import ppfs_pkg::*;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic clk_en_in = 1'b1;
    ppfs_apb_req_t apb_req_in = '0;
    logic [31:0] prdata_out;
    logic pready_out;
    logic pslverr_out;
    logic unlocked_out;
    logic [NUM_PORTS*32-1:0] func_sel_out;
    logic [NUM_PORTS*32-1:0] pin_type_out;
    logic [NUM_PORTS*16-1:0] pull_up_out;
    logic [NUM_PORTS*16-1:0] debounce_out;
    ppfs_pin_ctl_t [NUM_PORTS-1:0] pin_ctl_out;
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic [31:0] v;
    logic [15:0] base;
    logic err;
    // ------------------------------------------------------------------
    // Clock, device and helpers
    // ------------------------------------------------------------------
    always #2.5 core_clk_in = ~core_clk_in;
    ppfs_top dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
        .apb_req_in(apb_req_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .unlocked_out(unlocked_out), .func_sel_out(func_sel_out),
        .pin_type_out(pin_type_out), .pull_up_out(pull_up_out),
        .debounce_out(debounce_out), .pin_ctl_out(pin_ctl_out));
    task automatic give_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Setup, then access held until ready; data and error taken at that edge
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        apb_req_in <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge core_clk_in);
        apb_req_in.penable <= 1'b1;
        @(posedge core_clk_in);
        while (pready_out !== 1'b1) @(posedge core_clk_in);
        err = pslverr_out;
        rd = prdata_out;
        apb_req_in <= '0;
    endtask
    // Hang guard, generous for some 95 transfers
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        for (int p = 0; p < 6; p++) begin
            base = 16'h1000 + 16'(p << 8);
            apb(1'b0, base, 32'h0);
            chk("func reset", (p == 2) ? 32'h0010_0155 : 32'h0, rd);
            apb(1'b0, base + 16'h4, 32'h0);
            chk("type reset", (p == 2) ? 32'hFFAF_FE8A : (p == 5) ? 32'hFFF : '1, rd);
            apb(1'b0, base + 16'h8, 32'h0);
            chk("pull reset", 32'h0, rd);
            apb(1'b0, base + 16'hC, 32'h0);
            chk("debounce reset", 32'h0, rd);
        end
        // Writes while locked must vanish
        apb(1'b1, 16'h1000, 32'hFFFF_FFFF);
        apb(1'b0, 16'h1000, 32'h0);
        chk("locked write", 32'h0, rd);
        apb(1'b1, 16'h1FF0, 32'h15);
        apb(1'b1, 16'h1FF0, 32'h51);
        @(posedge core_clk_in);
        chk("unlocked", 32'h1, {31'h0, unlocked_out});
        apb(1'b0, 16'h1FF0, 32'h0);
        chk("key readback", 32'h1, rd);
        // Every field code on every port, fields independent
        for (int p = 0; p < 6; p++) begin
            base = 16'h1000 + 16'(p << 8);
            v = 32'hA5C3_96E4 ^ 32'(p);
            apb(1'b1, base, v);
            apb(1'b1, base + 16'h4, v);
            apb(1'b1, base + 16'h8, 32'h1234_ABCD);
            apb(1'b1, base + 16'hC, ~v);
            apb(1'b0, base, 32'h0);
            chk("func rw", (p == 5) ? (v & 32'hFFF) : v, rd);
            chk("func port", (p == 5) ? (v & 32'hFFF) : v, func_sel_out[p*32 +: 32]);
            apb(1'b0, base + 16'h4, 32'h0);
            chk("type rw", (p == 5) ? (v & 32'hFFF) : v, rd);
            apb(1'b0, base + 16'h8, 32'h0);
            chk("pull rw", 32'h0000_ABCD, rd);
            chk("pull out", 32'h0000_ABCD, {16'h0, pull_up_out[p*16 +: 16]});
            apb(1'b0, base + 16'hC, 32'h0);
            chk("debounce rw", {16'h0, ~v[15:0]}, rd);
            chk("debounce out", {16'h0, ~v[15:0]}, {16'h0, debounce_out[p*16 +: 16]});
        end
        chk("open drain", 32'h1, {31'h0, pin_ctl_out[0].open_drain[1]});
        chk("analog", 32'h1, {31'h0, pin_ctl_out[0].analog_en[3]});
        chk("analog no out", 32'h0, {31'h0, pin_ctl_out[0].out_en[3]});
        chk("analog no in", 32'h0, {31'h0, pin_ctl_out[0].in_en[3]});
        // Interrupt words are plain storage behind the same lock
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, 16'h1310 + 16'(r * 4), 32'h5A5A_0000 | 32'(r));
            apb(1'b0, 16'h1310 + 16'(r * 4), 32'h0);
            chk("irq rw", 32'h5A5A_0000 | 32'(r), rd);
        end
        apb(1'b1, 16'h1020, 32'hFFFF_FFFF);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, 16'h1020, 32'h0);
        chk("unmapped read", 32'h0, rd);
        // A write held while the clock enable is low must wait and land later
        clk_en_in <= 1'b0;
        fork
            apb(1'b1, 16'h1000, 32'h0000_00FF);
            begin
                repeat (4) @(posedge core_clk_in);
                chk("frozen", 32'hA5C3_96E4, func_sel_out[31:0]);
                clk_en_in <= 1'b1;
            end
        join
        apb(1'b0, 16'h1000, 32'h0);
        chk("thawed write", 32'h0000_00FF, rd);
        // Any other key relocks; a read mid-sequence spoils it
        apb(1'b1, 16'h1FF0, 32'h0);
        @(posedge core_clk_in);
        chk("relocked", 32'h0, {31'h0, unlocked_out});
        apb(1'b1, 16'h1000, 32'h0);
        apb(1'b0, 16'h1000, 32'h0);
        chk("relocked write", 32'h0000_00FF, rd);
        apb(1'b1, 16'h1FF0, 32'h15);
        apb(1'b0, 16'h1FF0, 32'h0);
        chk("key mid read", 32'h0, rd);
        apb(1'b1, 16'h1FF0, 32'h51);
        @(posedge core_clk_in);
        chk("read spoils key", 32'h0, {31'h0, unlocked_out});
        resetn_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        apb(1'b0, 16'h1200, 32'h0);
        chk("second reset", 32'h0010_0155, rd);
        apb(1'b0, 16'h1204, 32'h0);
        chk("second type reset", 32'hFFAF_FE8A, rd);
        give_verdict();
    end
endmodule // ppfs_top_tb
bind ppfs_top ppfs_props u_props (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
    .clk_en_in(clk_en_in), .apb_req_in(apb_req_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .unlocked_out(unlocked_out), .func_sel_out(func_sel_out),
    .pin_type_out(pin_type_out), .pin_ctl_out(pin_ctl_out));
